// ==== common/dvid_defs.svh ====
// Constants for the voltage-code stepper: timing, code widths, reference steps
// Assumes a single system clock; included by bare name
`ifndef DVID_DEFS_SVH
`define DVID_DEFS_SVH
`define SAMPLES_PER_CYCLE 6
`define VALID_READS 3
`define CODE_W 6
`define REF_W 16
`define FINE_STEP_UV 12500
`define COARSE_STEP_UV 25000
`define REF_UNIT_UV 12500
`define FINE_BASE_UNITS 67
`define FINE_WRAP_CODE 6'h15
`define FINE_HIGH_UNITS 149
`define FINE_LOW_UNITS 87
`define HALF_STEP_BASE_UNITS 88
`define COARSE_A_BASE_UNITS 64
`define PHASE_DIV_DEF 96
`define NO_LOAD_FINE_A 6'h3F
`define NO_LOAD_FINE_B 6'h3E
`define NO_LOAD_COARSE 5'h1F
`endif

// ==== common/dvid_pkg.sv ====
// Types for the voltage-code stepper
// Assumes dvid_defs.svh supplies widths
`include "dvid_defs.svh"
`default_nettype none
package dvid_pkg;
	typedef enum logic [1:0] {
		MODE_FINE,
		MODE_COARSE_A,
		MODE_COARSE_B
	} mode_e;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT_HALF,
		ST_SLEW
	} slew_e;
	typedef struct packed {
		logic [`REF_W-1:0] ref_units;
		logic no_load;
		logic busy;
	} ref_out_s;
endpackage
`default_nettype wire

// ==== core/code_sampler.sv ====
// Samples and validates the voltage code on sample enables
// Assumes code inputs already synchronised to clk_sys_i
`include "dvid_defs.svh"
`default_nettype none
module code_sampler
	import dvid_pkg::*;
#(
	parameter int READS = `VALID_READS
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic sample_i,
	input wire logic [`CODE_W-1:0] code_i,
	output logic [`CODE_W-1:0] code_o,
	output logic new_o
);
	typedef struct packed {
		logic [`CODE_W-1:0] last;
		logic [`CODE_W-1:0] held;
		logic [3:0] cnt;
		logic newp;
	} st_s;
	st_s s;
	st_s next_s;

	always_comb begin
		next_s = s;
		next_s.newp = 1'b0;
		if (sample_i) begin
			if (code_i != s.last) begin
				next_s.last = code_i;
				next_s.cnt = 4'h1;
			end else if (s.cnt < 4'(READS)) begin
				next_s.cnt = s.cnt + 4'h1;
			end
			// Accept after equal consecutive reads
			if (code_i == s.last && s.cnt == 4'(READS - 1) && code_i != s.held) begin
				next_s.held = code_i;
				next_s.newp = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign code_o = s.held;
	assign new_o = s.newp;
endmodule
`default_nettype wire

// ==== core/dynamic_voltage_code_stepper.sv ====
// Top of the dynamic voltage-code stepper: sampling, validation and reference slew
// Assumes pins asynchronous to clk_sys_i; phase clock derived by divider
`include "dvid_defs.svh"
`default_nettype none
module dynamic_voltage_code_stepper
	import dvid_pkg::*;
#(
	parameter int PHASE_DIV = `PHASE_DIV_DEF
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [4:0] voltage_code_inputs_i,
	input wire logic half_step_code_bit_i,
	input wire logic fine_step_mode_select_i,
	output logic [`REF_W-1:0] ref_units_o,
	output logic no_load_o,
	output logic busy_o,
	output logic phase_tick_o
);
	// ----------------------------------------
	// Constants
	// ----------------------------------------
	localparam int SAMPLE_DIV = PHASE_DIV / `SAMPLES_PER_CYCLE;
	localparam int HALF_DIV = PHASE_DIV / 2;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic fine1;
		logic fine2;
		logic [15:0] phase_cnt;
		logic [15:0] samp_cnt;
		logic [15:0] wait_cnt;
		slew_e st;
		logic [`REF_W-1:0] target;
		ref_out_s out;
		logic tick;
	} st_s;
	st_s s;
	st_s next_s;

	logic sample_en;
	logic [`CODE_W-1:0] code_now;
	logic [`CODE_W-1:0] code_held;
	logic code_new;
	mode_e mode;
	logic nl;
	logic [`REF_W-1:0] tgt;

	// ----------------------------------------
	// Mode and code decode
	// ----------------------------------------
	always_comb begin
		if (s.fine2) begin
			mode = MODE_FINE;
		end else if (s.sync2[0]) begin
			mode = MODE_COARSE_A;
		end else begin
			mode = MODE_COARSE_B;
		end
	end

	// Fine mode uses the half-step bit as code LSB
	assign code_now = (mode == MODE_FINE) ? s.sync2 : {1'b0, s.sync2[5:1]};
	assign sample_en = (s.samp_cnt == 16'(SAMPLE_DIV - 1));

	code_sampler #(
		.READS(`VALID_READS)
	) u_sampler (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.sample_i(sample_en),
		.code_i(code_now),
		.code_o(code_held),
		.new_o(code_new)
	);

	always_comb begin
		nl = 1'b0;
		tgt = '0;
		if (mode == MODE_FINE) begin
			nl = (code_held == `NO_LOAD_FINE_A) || (code_held == `NO_LOAD_FINE_B);
			// Table wraps below the wrap code; voltage falls as code rises
			if (code_held >= `FINE_WRAP_CODE) begin
				tgt = `REF_W'(`FINE_HIGH_UNITS) - `REF_W'(code_held);
			end else begin
				tgt = `REF_W'(`FINE_LOW_UNITS) - `REF_W'(code_held);
			end
		end else if (mode == MODE_COARSE_A) begin
			nl = (code_held[4:0] == `NO_LOAD_COARSE);
			tgt = `REF_W'(`HALF_STEP_BASE_UNITS) + `REF_W'({~code_held[4:0], 1'b0}) - 16'h2;
		end else begin
			nl = (code_held[4:0] == `NO_LOAD_COARSE);
			tgt = `REF_W'(`COARSE_A_BASE_UNITS) + `REF_W'({~code_held[4:0], 1'b0}) - 16'h2;
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.sync1 = {voltage_code_inputs_i, half_step_code_bit_i};
		next_s.sync2 = s.sync1;
		next_s.fine1 = fine_step_mode_select_i;
		next_s.fine2 = s.fine1;
		next_s.tick = 1'b0;
		next_s.phase_cnt = (s.phase_cnt == 16'(PHASE_DIV - 1)) ? 16'h0 : s.phase_cnt + 16'h1;
		next_s.samp_cnt = sample_en ? 16'h0 : s.samp_cnt + 16'h1;
		if (s.phase_cnt == 16'(PHASE_DIV - 1)) begin
			next_s.tick = 1'b1;
		end
		if (code_new) begin
			next_s.out.no_load = nl;
			if (!nl) begin
				next_s.target = tgt;
				if (mode == MODE_FINE) begin
					next_s.out.ref_units = tgt;
					next_s.st = ST_IDLE;
				end else begin
					next_s.st = ST_WAIT_HALF;
					next_s.wait_cnt = 16'h0;
				end
			end
		end else begin
			unique case (s.st)
				ST_IDLE: begin
				end
				ST_WAIT_HALF: begin
					next_s.wait_cnt = s.wait_cnt + 16'h1;
					if (s.wait_cnt == 16'(HALF_DIV - 1)) begin
						next_s.st = ST_SLEW;
					end
				end
				ST_SLEW: begin
					if (s.out.ref_units == s.target) begin
						next_s.st = ST_IDLE;
					end else if (s.tick) begin
						// One reference unit is 12.5 mV
						if (s.out.ref_units < s.target) begin
							next_s.out.ref_units = s.out.ref_units + 16'h1;
						end else begin
							next_s.out.ref_units = s.out.ref_units - 16'h1;
						end
					end
				end
			endcase
		end
		next_s.out.busy = (next_s.st != ST_IDLE);
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign ref_units_o = s.out.ref_units;
	assign no_load_o = s.out.no_load;
	assign busy_o = s.out.busy;
	assign phase_tick_o = s.tick;
endmodule
`default_nettype wire

// ==== tb/dvid_stepper_chk.sv ====
// Port checker for the voltage-code stepper
// Assumes PHASE_DIV of at least 12
`include "dvid_defs.svh"
`default_nettype none
module dvid_stepper_chk #(
	parameter int PHASE_DIV = 12
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [4:0] voltage_code_inputs_i,
	input wire logic half_step_code_bit_i,
	input wire logic fine_step_mode_select_i,
	input wire logic [`REF_W-1:0] ref_units_o,
	input wire logic no_load_o,
	input wire logic busy_o,
	input wire logic phase_tick_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_hold;
		$stable(ref_units_o) [*5];
	endsequence
	property p_tick;
		phase_tick_o |=> !phase_tick_o [*8];
	endproperty
	a_tick: assert property (p_tick) else $error("tick");
	property p_step;
		busy_o && $changed(ref_units_o) |-> ref_units_o == $past(ref_units_o) + 16'h0001
			|| ref_units_o == $past(ref_units_o) - 16'h0001;
	endproperty
	a_step: assert property (p_step) else $error("step");
	property p_fine;
		fine_step_mode_select_i [*8] |=> !busy_o;
	endproperty
	a_fine: assert property (p_fine) else $error("slew");
	property p_wait;
		$rose(busy_o) |-> s_hold;
	endproperty
	a_wait: assert property (p_wait) else $error("wait");
	property p_valid;
		($changed(voltage_code_inputs_i) || $changed(half_step_code_bit_i)) && !busy_o
			|=> $stable(ref_units_o) [*3];
	endproperty
	a_valid: assert property (p_valid) else $error("early");
	property p_nl_hold;
		no_load_o && $past(no_load_o) |-> $stable(ref_units_o);
	endproperty
	a_nl_hold: assert property (p_nl_hold) else $error("noload ref");
	property p_nl_cause;
		$rose(no_load_o) |-> voltage_code_inputs_i == 5'h1F;
	endproperty
	a_nl_cause: assert property (p_nl_cause) else $error("noload");
	property p_stop;
		$fell(busy_o) |=> $stable(ref_units_o) [*4];
	endproperty
	a_stop: assert property (p_stop) else $error("stop");
endmodule
bind dynamic_voltage_code_stepper dvid_stepper_chk #(.PHASE_DIV(PHASE_DIV)) chk_u (
	.clk_sys_i, .rst_n_i, .voltage_code_inputs_i, .half_step_code_bit_i,
	.fine_step_mode_select_i, .ref_units_o, .no_load_o, .busy_o, .phase_tick_o);
`default_nettype wire

// ==== tb/host_code_driver.sv ====
// Processor-side model driving the voltage code pins
// Assumes the bench sets target, mode and table at clock edges
`default_nettype none
module host_code_driver (
	input wire logic clk_sys_i,
	input wire logic [5:0] target_i,
	input wire logic fine_i,
	input wire logic table_i,
	output logic [4:0] pins_o,
	output logic half_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] cur = 6'h00;
	logic [4:0] cnt = 5'h00;
	always @(posedge clk_sys_i) begin
		cnt <= cnt + 5'h01;
		if (!fine_i) begin
			cur <= target_i;
		end else if (cnt == 5'h00 && cur != target_i) begin
			cur <= (cur < target_i) ? cur + 6'h01 : cur - 6'h01;
		end
	end
	assign pins_o = fine_i ? cur[5:1] : cur[4:0];
	assign half_o = fine_i ? cur[0] : table_i;
endmodule
`default_nettype wire

// ==== tb/tb_dynamic_voltage_code_stepper.sv ====
// Bench for the voltage-code stepper
// Assumes PHASE_DIV of 12 and two units per coarse code
`include "dvid_defs.svh"
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module tb_dynamic_voltage_code_stepper;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 0;
	logic rst_n_i = 0;
	logic [5:0] target = 6'h1E;
	logic fine = 0;
	logic tsel = 1;
	logic [4:0] pins;
	logic half;
	logic [`REF_W-1:0] ref_units, r0;
	logic no_load, busy;
	int num_errors = 0;
	int n_tests = 0;
	logic [5:0] rows [6] = '{6'h3E, 6'h2A, 6'h39, 6'h00, 6'h1E, 6'h05};
	always #5 clk_sys_i = ~clk_sys_i;
	host_code_driver host_u (.clk_sys_i, .target_i(target), .fine_i(fine), .table_i(tsel),
		.pins_o(pins), .half_o(half));
	dynamic_voltage_code_stepper #(.PHASE_DIV(12)) dut_u (.clk_sys_i, .rst_n_i,
		.voltage_code_inputs_i(pins), .half_step_code_bit_i(half),
		.fine_step_mode_select_i(fine), .ref_units_o(ref_units), .no_load_o(no_load),
		.busy_o(busy), .phase_tick_o());
	function automatic logic [`REF_W-1:0] exp_ref(input logic [5:0] r);
		return (r[5] ? 16'h0058 : 16'h0040) + 16'(2 * (30 - int'(r[4:0])));
	endfunction
	task automatic settle(input logic [`REF_W-1:0] e);
		for (int i = 0; i < 3000 && !(busy === 1'b0 && ref_units === e); i++) begin
			@(negedge clk_sys_i);
		end
	endtask
	task automatic end_of_test();
		$display("Checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk_sys_i);
		num_errors++;
		end_of_test();
	end
	initial begin
		repeat (15) @(posedge clk_sys_i);
		#1;
		`CHK("reset", 18'h00000, {ref_units, no_load, busy})
		@(posedge clk_sys_i);
		rst_n_i <= 1;
		foreach (rows[i]) begin
			@(posedge clk_sys_i);
			{tsel, target} <= {rows[i][5], 1'b0, rows[i][4:0]};
			settle(exp_ref(rows[i]));
			`CHK("coarse ref", exp_ref(rows[i]), ref_units)
		end
		@(posedge clk_sys_i);
		{fine, target} <= {1'b1, 6'h04};
		repeat (100) @(negedge clk_sys_i);
		r0 = ref_units;
		for (int k = 5; k < 8; k++) begin
			@(posedge clk_sys_i);
			target <= 6'(k);
			repeat (60) @(negedge clk_sys_i);
			`CHK("fine delta", 16'h0001, (ref_units > r0) ? ref_units - r0 : r0 - ref_units)
			`CHK("fine busy", 1'b0, busy)
			r0 = ref_units;
		end
		@(posedge clk_sys_i);
		{fine, target} <= {1'b0, 6'h1F};
		repeat (60) @(negedge clk_sys_i);
		r0 = ref_units;
		`CHK("no load", 1'b1, no_load)
		repeat (100) @(negedge clk_sys_i);
		`CHK("no load ref", r0, ref_units)
		end_of_test();
	end
endmodule
`default_nettype wire
